// ===== bench/nptx_arb_model.sv
// arbitration-side model: asks for the next page, then reports it exchanged
// assumes one clock shared with the register block
`timescale 1ns/100ps
module nptx_arb_model (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	// bench control
	input  wire logic       i_go,
	input  wire logic [3:0] i_gap,
	// arbitration pulses
	output logic            o_np_request,
	output logic            o_np_exchanged
);
	logic [3:0] cnt;  // cycles left before the exchange
	logic       busy; // a page is in flight

	// one request per go, exchange gap plus one cycles after the request, prompt or slow
	always @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_np_request <= 1'b0;
			o_np_exchanged <= 1'b0;
			busy <= 1'b0;
			cnt <= 4'h0;
		end else begin
			o_np_request <= i_go & ~busy;
			o_np_exchanged <= busy & (cnt == 4'h0);
			if (i_go && !busy) begin
				busy <= 1'b1;
				cnt <= i_gap;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the next page word register
// assumes the arbitration model drives the page handshake
`timescale 1ns/100ps
module testbench;
	import nptx_pkg::*;
	logic        clk, rst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, req, exch, vld, msg, go;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, gap;
	logic [1:0]  bresp, rresp;
	nptx_word_t  word;
	int          n_mismatch, n_compared, cyc;

	nptx_regs dut (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(ce),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_np_request(req),
		.i_np_exchanged(exch), .o_np_tx_word(word), .o_np_tx_valid(vld), .o_np_tx_message(msg));
	nptx_arb_model arb (.i_core_clk(clk), .i_sys_rst(rst), .i_go(go), .i_gap(gap),
		.o_np_request(req), .o_np_exchanged(exch));

	// clock and cycle ceiling
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch = n_mismatch + 1;
			conclude();
		end
	end

	// verdict and end of run
	task automatic conclude();
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one comparison, counted
	task automatic chk(input logic ok, input string m);
		n_compared = n_compared + 1;
		if (ok !== 1'b1) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	// axi write, address and data offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		logic ad;
		logic wd;
		int   t;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		t = 0;
		while (!(ad && wd) && t < 50) begin
			@(posedge clk);
			t++;
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1 && t < 50) begin
			@(posedge clk);
			t++;
		end
		bready <= 1'b0;
		chk(bvalid === 1'b1 && bresp === r, "write response");
	endtask

	// axi read with expected data and response
	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int t;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (arready !== 1'b1 && t < 50);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && t < 50) begin
			@(posedge clk);
			t++;
		end
		rready <= 1'b0;
		chk(rvalid === 1'b1 && rdata === e && rresp === r, "read data");
	endtask

	// wait for the held flag to reach a level
	task automatic wait_vld(input logic lvl);
		int t;
		t = 0;
		while (vld !== lvl && t < 40) begin
			@(posedge clk);
			#1;
			t++;
		end
		chk(vld === lvl, "held flag");
	endtask

	// launch one page through the arbitration model
	task automatic page(input logic [3:0] g);
		@(posedge clk);
		go <= 1'b1;
		gap <= g;
		@(posedge clk);
		go <= 1'b0;
		wait_vld(1'b1);
	endtask

	initial begin
		{clk, awvalid, wvalid, bready, arvalid, rready, go} = '0;
		{awaddr, araddr, wdata, wstrb, gap} = '0;
		{n_mismatch, n_compared, cyc} = '0;
		rst = 1'b1;
		ce = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		axr(8'h1C, 32'h0000_2001, 2'h0);
		axr(8'h20, 32'h0000_0000, 2'h0);
		axw(8'h1C, 32'hFFFF_FFFF, 4'h3, 2'h0);
		axr(8'h1C, 32'h0000_B7FF, 2'h0);
		axw(8'h1C, 32'h0000_0000, 4'h3, 2'h0);
		axr(8'h1C, 32'h0000_0000, 2'h0);
		axw(8'h1C, 32'hFFFF_FF55, 4'h1, 2'h0);
		axw(8'h24, 32'hFFFF_FFFF, 4'h3, 2'h2);
		axr(8'h24, 32'h0000_0000, 2'h2);
		axr(8'h1C, 32'h0000_0055, 2'h0);
		// whole word loaded before the page is asked for
		axw(8'h1C, 32'h0000_B123, 4'h3, 2'h0);
		page(4'hF);
		chk(word === 16'hB123 && msg === 1'b1, "message page snapshot");
		axr(8'h20, 32'h0000_0001, 2'h0);
		wait_vld(1'b0);
		axr(8'h1C, 32'h0000_B923, 2'h0);
		axw(8'h1C, 32'h0000_0ABC, 4'h3, 2'h0);
		axr(8'h1C, 32'h0000_0ABC, 2'h0);
		page(4'h0);
		chk(word === 16'h0ABC && msg === 1'b0, "unformatted snapshot");
		wait_vld(1'b0);
		axr(8'h1C, 32'h0000_02BC, 2'h0);
		// clock enable low: request and exchange pulses must leave no trace
		@(posedge clk);
		ce <= 1'b0;
		go <= 1'b1;
		gap <= 4'h0;
		@(posedge clk);
		go <= 1'b0;
		repeat (5) @(posedge clk);
		ce <= 1'b1;
		chk(vld === 1'b0 && word === 16'h0ABC, "frozen while disabled");
		axr(8'h1C, 32'h0000_02BC, 2'h0);
		conclude();
	end
endmodule

// ===== verilog/nptx_params.svh
// constants for the next page transmit word block
// assumes nothing; included by bare name wherever offsets or resets are needed
`ifndef NPTX_PARAMS_SVH
`define NPTX_PARAMS_SVH

// register indices; byte address is four times the index
`define NPTX_IDX_WORD   6'h07
`define NPTX_IDX_STAT   6'h08

// field positions inside the next page word
`define NPTX_BIT_MORE   15
`define NPTX_BIT_TYPE   13
`define NPTX_BIT_ACK    12
`define NPTX_CODE_HI_MSB 10
`define NPTX_CODE_HI_LSB 8
`define NPTX_CODE_LO_MSB 7
`define NPTX_CODE_LO_LSB 0

// status register field position
`define NPTX_BIT_HELD   0

// reset value: message page, null message code, all flags clear
`define NPTX_RST_WORD   16'h2001

// axi4-lite response codes
`define NPTX_RESP_OKAY  2'h0
`define NPTX_RESP_SLVERR 2'h2

`endif

// ===== verilog/nptx_pkg.sv
// types shared by the next page transmit word block
// assumes the params header is compiled alongside it
package nptx_pkg;

	// one next page link code word, msb first
	typedef struct packed {
		logic        more_pages;        // another next page follows
		logic        rsvd;              // always zero
		logic        page_type;         // 1 message page, 0 unformatted
		logic        comply_ack;        // local device can comply
		logic        transmit_toggle;   // kept by hardware only
		logic [10:0] code;              // message or unformatted code
	} nptx_word_t;

endpackage

// ===== verilog/nptx_regs.sv
// next page transmit word register with an axi4-lite slave port
// assumes arbitration logic on the same clock pulses request and exchanged
//
// Summary of operation
// - register contents are sent as local next page
// - bit 15 more pages flag, writable, resets 0
// - bit 14 ignores writes, reads zero
// - bit 13 page type, writable, resets 1
// - bit 12 comply acknowledge, writable, resets 0
// - toggle read-only, inverse of last exchanged toggle
// - low 11 bits code, writable, sent as code
// - code is message when page type is 1
// - code resets to one, the null page
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "nptx_params.svh"
module nptx_regs
	import nptx_pkg::*;
(
	// clock, reset, enable
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	// axi4-lite write address and data
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	// arbitration side
	input  wire logic        i_np_request,
	input  wire logic        i_np_exchanged,
	output nptx_word_t       o_np_tx_word,
	output logic             o_np_tx_valid,
	output logic             o_np_tx_message
);

	// write channel state
	logic        aw_held;          // write address taken, not yet used
	logic        w_held;           // write data taken, not yet used
	logic [7:0]  awaddr_q;         // held write address
	logic [31:0] wdata_q;          // held write data
	logic [3:0]  wstrb_q;          // held byte strobes
	logic        next_aw_held;
	logic        next_w_held;
	logic [7:0]  next_awaddr;
	logic [31:0] next_wdata;
	logic [3:0]  next_wstrb;
	logic        next_awready;
	logic        next_wready;
	logic [1:0]  next_bresp;
	logic        next_bvalid;
	logic        wr_fire;          // both halves present, write happens now
	logic        wr_hit_word;      // write aimed at the next page word

	// read channel state
	logic        next_arready;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        next_rvalid;
	logic        rd_take;          // read address accepted this cycle

	// the next page word itself
	nptx_word_t  np_word;          // software copy
	nptx_word_t  next_np_word;

	// a write happens once address and data are both held
	assign wr_fire     = aw_held && w_held && !o_s_axi_bvalid;
	assign wr_hit_word = (awaddr_q[7:2] == `NPTX_IDX_WORD);
	assign rd_take     = i_s_axi_arvalid && o_s_axi_arready;

	// write channel next values
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_awaddr  = awaddr_q;
		next_wdata   = wdata_q;
		next_wstrb   = wstrb_q;
		next_bresp   = o_s_axi_bresp;
		next_bvalid  = o_s_axi_bvalid;
		// take address and data in either order
		if (i_s_axi_awvalid && o_s_axi_awready) begin
			next_aw_held = 1'b1;
			next_awaddr  = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && o_s_axi_wready) begin
			next_w_held = 1'b1;
			next_wdata  = i_s_axi_wdata;
			next_wstrb  = i_s_axi_wstrb;
		end
		// complete the write and raise the response
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			if (wr_hit_word || awaddr_q[7:2] == `NPTX_IDX_STAT) begin
				next_bresp = `NPTX_RESP_OKAY;
			end else begin
				next_bresp = `NPTX_RESP_SLVERR;
			end
		end
		// response taken by the master
		if (o_s_axi_bvalid && i_s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// one write under way at a time
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	// write channel registers
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			awaddr_q        <= 8'h00;
			wdata_q         <= 32'h0000_0000;
			wstrb_q         <= 4'h0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready  <= 1'b0;
			o_s_axi_bresp   <= `NPTX_RESP_OKAY;
			o_s_axi_bvalid  <= 1'b0;
		end else if (i_clk_en) begin
			aw_held         <= next_aw_held;
			w_held          <= next_w_held;
			awaddr_q        <= next_awaddr;
			wdata_q         <= next_wdata;
			wstrb_q         <= next_wstrb;
			o_s_axi_awready <= next_awready;
			o_s_axi_wready  <= next_wready;
			o_s_axi_bresp   <= next_bresp;
			o_s_axi_bvalid  <= next_bvalid;
		end
	end

	// next page word next values
	always_comb begin
		next_np_word = np_word;
		if (wr_fire && wr_hit_word) begin
			// low byte of the code
			if (wstrb_q[0]) begin
				next_np_word.code[7:0] = wdata_q[`NPTX_CODE_LO_MSB:`NPTX_CODE_LO_LSB];
			end
			// high byte: flags and top of the code
			if (wstrb_q[1]) begin
				next_np_word.more_pages = wdata_q[`NPTX_BIT_MORE];
				next_np_word.page_type  = wdata_q[`NPTX_BIT_TYPE];
				next_np_word.comply_ack = wdata_q[`NPTX_BIT_ACK];
				next_np_word.code[10:8] = wdata_q[`NPTX_CODE_HI_MSB:`NPTX_CODE_HI_LSB];
			end
		end
		// toggle follows the exchange, never software
		if (i_np_exchanged) begin
			next_np_word.transmit_toggle = !o_np_tx_word.transmit_toggle;
		end
		// reserved bit cannot be set
		next_np_word.rsvd = 1'b0;
	end

	// next page word register
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			np_word <= `NPTX_RST_WORD;
		end else if (i_clk_en) begin
			np_word <= next_np_word;
		end
	end

	// read channel next values
	always_comb begin
		// arready returns whenever no read data is pending
		next_arready = o_s_axi_arready || !o_s_axi_rvalid;
		next_rdata   = o_s_axi_rdata;
		next_rresp   = o_s_axi_rresp;
		next_rvalid  = o_s_axi_rvalid;
		// data taken by the master: accept the next address
		if (o_s_axi_rvalid && i_s_axi_rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
		// decode the address and load the answer
		if (rd_take) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = `NPTX_RESP_OKAY;
			if (i_s_axi_araddr[7:2] == `NPTX_IDX_WORD) begin
				next_rdata = {16'h0000, np_word};
			end else if (i_s_axi_araddr[7:2] == `NPTX_IDX_STAT) begin
				next_rdata = 32'h0000_0000;
				next_rdata[`NPTX_BIT_HELD] = o_np_tx_valid;
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = `NPTX_RESP_SLVERR;
			end
		end
	end

	// read channel registers; arready rises one cycle after reset
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rdata   <= 32'h0000_0000;
			o_s_axi_rresp   <= `NPTX_RESP_OKAY;
			o_s_axi_rvalid  <= 1'b0;
		end else if (i_clk_en) begin
			o_s_axi_arready <= next_arready;
			o_s_axi_rdata   <= next_rdata;
			o_s_axi_rresp   <= next_rresp;
			o_s_axi_rvalid  <= next_rvalid;
		end
	end

	// snapshot of the whole word at the request, so a half written word is never seen
	nptx_word_latch u_latch (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_clk_en   (i_clk_en),
		.i_load     (i_np_request),
		.i_clear    (i_np_exchanged),
		.i_word     (np_word),
		.o_word     (o_np_tx_word),
		.o_held     (o_np_tx_valid),
		.o_message  (o_np_tx_message)
	);

	// checks on the word, its fields and the hand-over
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	a_request_sends_word: assert property (
		(i_clk_en && i_np_request) |=> (o_np_tx_word == $past(np_word) && o_np_tx_valid))
		else $error("requested word not handed to arbitration");

	a_more_pages_write: assert property (
		(i_clk_en && wr_fire && wr_hit_word && wstrb_q[1])
		|=> np_word.more_pages == $past(wdata_q[`NPTX_BIT_MORE]))
		else $error("more pages flag did not take the write");

	a_reserved_zero: assert property (
		(o_s_axi_rvalid |-> o_s_axi_rdata[14] == 1'b0) and (np_word.rsvd == 1'b0))
		else $error("reserved bit not zero");

	a_page_type_write: assert property (
		(i_clk_en && wr_fire && wr_hit_word && wstrb_q[1])
		|=> np_word.page_type == $past(wdata_q[`NPTX_BIT_TYPE]))
		else $error("page type did not take the write");

	a_comply_ack_write: assert property (
		(i_clk_en && wr_fire && wr_hit_word && wstrb_q[1])
		|=> np_word.comply_ack == $past(wdata_q[`NPTX_BIT_ACK]))
		else $error("comply acknowledge did not take the write");

	a_toggle_inverts: assert property (
		(i_clk_en && i_np_exchanged)
		|=> np_word.transmit_toggle == !$past(o_np_tx_word.transmit_toggle))
		else $error("toggle not inverse of exchanged toggle");

	a_toggle_read_only: assert property (
		(!i_np_exchanged) |=> $stable(np_word.transmit_toggle))
		else $error("toggle changed without an exchange");

	a_code_write: assert property (
		(i_clk_en && wr_fire && wr_hit_word && wstrb_q[1] && wstrb_q[0])
		|=> np_word.code == $past(wdata_q[10:0]))
		else $error("code field did not take the write");

	a_message_flag: assert property (
		o_np_tx_valid |-> o_np_tx_message == o_np_tx_word.page_type)
		else $error("message flag disagrees with sent page type");

	a_reset_defaults: assert property (
		$past(i_sys_rst) |-> (np_word.code == 11'h001 && np_word.page_type && !np_word.more_pages
			&& !np_word.comply_ack && !np_word.transmit_toggle))
		else $error("word fields not at reset values");

	a_exchange_releases: assert property (
		(i_clk_en && i_np_exchanged && !i_np_request)
		|=> !o_np_tx_valid)
		else $error("held flag stayed set after exchange");

	a_message_follows: assert property (
		(i_clk_en && i_np_request)
		|=> o_np_tx_message == $past(np_word.page_type))
		else $error("message flag not taken from page type");

	a_read_word: assert property (
		(i_clk_en && rd_take && i_s_axi_araddr[7:2] == `NPTX_IDX_WORD)
		|=> (o_s_axi_rvalid && o_s_axi_rdata[15:0] == $past(np_word) && o_s_axi_rdata[31:16] == 16'h0000))
		else $error("word read back wrong");

	a_status_held: assert property (
		(i_clk_en && rd_take && i_s_axi_araddr[7:2] == `NPTX_IDX_STAT)
		|=> o_s_axi_rdata[`NPTX_BIT_HELD] == $past(o_np_tx_valid))
		else $error("status held bit wrong");

endmodule

// ===== verilog/nptx_word_latch.sv
// holding register for the word handed to the arbitration logic
// assumes load and clear pulses come from logic on the same clock
`timescale 1ns/100ps
`include "nptx_params.svh"
module nptx_word_latch
	import nptx_pkg::*;
(
	// clock, reset, enable
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_clk_en,
	// load and release
	input  wire logic       i_load,
	input  wire logic       i_clear,
	input  wire nptx_word_t i_word,
	// held word
	output nptx_word_t      o_word,
	output logic            o_held,
	output logic            o_message
);

	nptx_word_t next_word;   // next held word
	logic       next_held;   // next held flag
	logic       next_message; // next message flag

	// next values: a load in the same cycle as a clear keeps the word held
	always_comb begin
		next_word    = o_word;
		next_held    = o_held;
		next_message = o_message;
		if (i_clear) begin
			next_held = 1'b0;
		end
		if (i_load) begin
			next_word    = i_word;
			next_held    = 1'b1;
			next_message = i_word.page_type;
		end
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_word    <= `NPTX_RST_WORD;
			o_held    <= 1'b0;
			o_message <= 1'b1;
		end else if (i_clk_en) begin
			o_word    <= next_word;
			o_held    <= next_held;
			o_message <= next_message;
		end
	end

endmodule
